// ### src/sysopt_pkg.sv
// Package: register map, field positions, reset values and types for the system option bank
package sysopt_pkg;

    // Register byte offsets (word aligned on the bus)
    localparam logic [11:0] OFF_OPTIONS_ONE  = 12'h000;
    localparam logic [11:0] OFF_OPTIONS_TWO  = 12'h004;
    localparam logic [11:0] OFF_IDENT_HIGH   = 12'h008;
    localparam logic [11:0] OFF_IDENT_LOW    = 12'h00C;
    localparam logic [11:0] OFF_POWER_MON    = 12'h010;
    localparam logic [11:0] OFF_RESET_CAUSE  = 12'h014;
    localparam logic [11:0] OFF_WDOG_CTRL    = 12'h018;

    // Options one fields
    localparam int OPT1_TIMEOUT_HI = 7;
    localparam int OPT1_TIMEOUT_LO = 6;
    localparam int OPT1_STOP       = 5;
    localparam int OPT1_SPARE      = 4;
    // Options two fields
    localparam int OPT2_CLKSEL     = 7;
    localparam int OPT2_WINDOW     = 6;
    // Ident high fields
    localparam int IDH_FAMILY      = 7;
    // Power monitor fields
    localparam int PM_WFLAG        = 7;
    localparam int PM_WACK         = 6;
    localparam int PM_WIE          = 5;
    localparam int PM_DRE          = 4;
    localparam int PM_DSE          = 3;
    localparam int PM_DE           = 2;
    localparam int PM_REFERENCE_BUFFER_ENABLE         = 0;

    // Reset values
    localparam logic [7:0] OPT1_RESET = 8'hD3;
    localparam logic [7:0] OPT2_RESET = 8'h00;
    localparam logic [7:0] PM_RESET   = 8'h1C;
    // Mask of the power monitor bits that are written-once
    localparam logic [7:0] PM_ONCE_MASK = 8'h14;
    // Mask of the power monitor bits that always take writes
    localparam logic [7:0] PM_FREE_MASK = 8'h29;

    // Part number: arbitrary neutral value
    localparam logic [11:0] PART_NUMBER_DEFAULT = 12'h05A;
    // Value shown in the reserved ident bits
    localparam logic [2:0]  IDH_RESERVED = 3'h0;

    // Watchdog service keys
    localparam logic [7:0] KEY_FIRST  = 8'h55;
    localparam logic [7:0] KEY_SECOND = 8'hAA;

    // Watchdog periods in ticks, indexed by timeout field, one set per clock source
    localparam logic [17:0] WD_SLOW_SHORT = 18'h0_0020;
    localparam logic [17:0] WD_SLOW_MID   = 18'h0_0100;
    localparam logic [17:0] WD_SLOW_LONG  = 18'h0_0400;
    localparam logic [17:0] WD_BUS_SHORT  = 18'h0_2000;
    localparam logic [17:0] WD_BUS_MID    = 18'h0_8000;
    localparam logic [17:0] WD_BUS_LONG   = 18'h3_FFFF;

    // Bus transfer types and hsize for a word
    localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
    localparam logic [2:0] HSIZE_WORD    = 3'b010;

    typedef struct packed {
        logic [11:0] addr;
        logic        write;
        logic        valid;
    } bus_req_t;

    typedef struct packed {
        logic stop_request;
        logic slow_tick;
        logic supply_warning;
        logic supply_detect;
    } sys_in_t;

    typedef struct packed {
        logic illegal_opcode_reset;
        logic watchdog_reset;
        logic supply_detect_reset;
        logic supply_warning_irq;
        logic reference_buffer_enable;
        logic supply_detect_active;
        logic stop_permitted;
    } sys_out_t;

    typedef enum logic [2:0] {
        WD_IDLE  = 3'b001,
        WD_ARMED = 3'b010,
        WD_RESET = 3'b100
    } wd_state_t;

endpackage

// ### src/system_option_power_monitor_regs.sv
// System option, device identification and power monitor register bank on AHB-Lite
`timescale 1ns/10ps

// What this block does
// R01: Both option registers take only the first write after reset; reads always allowed.
// R02: Startup software writes option register one early, even with reset values.
// R03: Option one bit 4 stores and returns written data but controls nothing.
// R04: Option one bits 7:6 pick watchdog period together with clock select.
// R05: Option one bit 5 permits stop; if clear, stop forces illegal-opcode reset.
// R06: Option two bit 7 picks watchdog clock: 0 slow 1-kHz tick, 1 bus clock.
// R07: Windowed mode: service only in last 25%; writes earlier reset device.
// R08: Window mode applies only when clock select is 1.
// R09: Identification registers are read-only.
// R10: Ident high bit 7 always reads 1; writes ignored.
// R11: Ident high bits 6:4 reserved, read undefined (here zero), writes ignored.
// R12: 12-bit part number split across ident high 3:0 and ident low 7:0.
// R13: Warning flag sets on low supply, also after reset if already low.
// R14: Writing 1 to acknowledge clears the warning flag only if warning is absent.
// R15: Interrupt enable bit 5 requests interrupt while warning flag is 1.
// R16: Write-once detect-reset enable forces reset on detect event when detection on.
// R17: Bit 3 keeps detect running in stop mode when 1, disables it when 0.
// R18: Write-once detect enable switches detect logic and qualifies bits 4 and 3.
// R19: Bit 0 enables the reference buffer; disabled when 0.
// R20: Watchdog cleared by 0x55 then 0xAA; other values reset when watchdog on.
// R21: Timeout field 0 disables the watchdog entirely.
// R22: Each write-once item has a written flag cleared by reset, set on first write.
module system_option_power_monitor_regs #(
    parameter logic [11:0] PART_NUMBER = sysopt_pkg::PART_NUMBER_DEFAULT
) (
    // Clock and reset
    input  wire logic                 clk_sys,
    input  wire logic                 nrst,
    // AHB-Lite slave
    input  wire logic                 hsel,
    input  wire logic [31:0]          haddr,
    input  wire logic [1:0]           htrans,
    input  wire logic                 hwrite,
    input  wire logic [2:0]           hsize,
    input  wire logic [31:0]          hwdata,
    input  wire logic                 hready,
    output logic [31:0]               hrdata,
    output logic                      hreadyout,
    output logic                      hresp,
    // System side
    input  wire sysopt_pkg::sys_in_t  sys_in,
    output sysopt_pkg::sys_out_t      sys_out
);

    ////////////////////////////////////////////////////////////////////////////
    // Bus address phase capture

    sysopt_pkg::bus_req_t req_ff;
    logic                 take_req;

    assign take_req  = hsel && hready && (htrans == sysopt_pkg::HTRANS_NONSEQ);
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            req_ff <= '0;
        end else if (hready) begin
            req_ff.valid <= take_req;
            req_ff.write <= hwrite;
            req_ff.addr  <= haddr[11:0];
        end
    end

    function automatic logic hit(input sysopt_pkg::bus_req_t r, input logic [11:0] off);
        hit = r.valid && r.write && (r.addr == off);
    endfunction

    logic [7:0] wdata;
    logic       wr_opt1;
    logic       wr_opt2;
    logic       wr_pm;
    logic       wr_cause;

    assign wdata    = hwdata[7:0];
    assign wr_opt1  = hit(req_ff, sysopt_pkg::OFF_OPTIONS_ONE);
    assign wr_opt2  = hit(req_ff, sysopt_pkg::OFF_OPTIONS_TWO);
    assign wr_pm    = hit(req_ff, sysopt_pkg::OFF_POWER_MON);
    assign wr_cause = hit(req_ff, sysopt_pkg::OFF_RESET_CAUSE);

    ////////////////////////////////////////////////////////////////////////////
    // Write-once option registers

    logic [7:0] opt1_ff;
    logic [7:0] opt2_ff;
    logic       opt1_done_ff;
    logic       opt2_done_ff;
    logic       pm_done_ff;

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            opt1_ff      <= sysopt_pkg::OPT1_RESET;
            opt1_done_ff <= 1'b0;
        end else if (wr_opt1 && !opt1_done_ff) begin // see R01
            opt1_ff      <= wdata;                   // see R03
            opt1_done_ff <= 1'b1;                    // see R22
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            opt2_ff      <= sysopt_pkg::OPT2_RESET;
            opt2_done_ff <= 1'b0;
        end else if (wr_opt2 && !opt2_done_ff) begin // see R01
            opt2_ff      <= {wdata[7:6], 6'h00};
            opt2_done_ff <= 1'b1;                    // see R22
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Power monitor control

    logic [7:0] pm_ff;
    logic       wflag_ff;
    logic       detect_on;
    logic       in_stop_ff;

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            pm_ff      <= sysopt_pkg::PM_RESET;
            pm_done_ff <= 1'b0;
        end else if (wr_pm) begin
            // Free bits always update; once-bits only on the first write
            pm_ff[sysopt_pkg::PM_WIE]  <= wdata[sysopt_pkg::PM_WIE];
            pm_ff[sysopt_pkg::PM_DSE]  <= wdata[sysopt_pkg::PM_DSE];
            pm_ff[sysopt_pkg::PM_REFERENCE_BUFFER_ENABLE] <= wdata[sysopt_pkg::PM_REFERENCE_BUFFER_ENABLE]; // see R19
            if (!pm_done_ff) begin                                    // see R22
                pm_ff[sysopt_pkg::PM_DRE] <= wdata[sysopt_pkg::PM_DRE]; // see R16
                pm_ff[sysopt_pkg::PM_DE]  <= wdata[sysopt_pkg::PM_DE];  // see R18
                pm_done_ff                <= 1'b1;
            end
        end
    end

    // Flag comes up clear and sets on the first cycle the comparator is low,
    // which also covers a supply already low when reset releases.
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            wflag_ff <= 1'b0;
        end else if (sys_in.supply_warning) begin    // see R13
            wflag_ff <= 1'b1;
        end else if (wr_pm && wdata[sysopt_pkg::PM_WACK]) begin // see R14
            wflag_ff <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            in_stop_ff <= 1'b0;
        end else begin
            in_stop_ff <= sys_in.stop_request && opt1_ff[sysopt_pkg::OPT1_STOP];
        end
    end

    assign detect_on = pm_ff[sysopt_pkg::PM_DE]
                    && (!in_stop_ff || pm_ff[sysopt_pkg::PM_DSE]); // see R17 see R18

    ////////////////////////////////////////////////////////////////////////////
    // Watchdog period and window

    logic [1:0]  wd_sel;
    logic        wd_busclk;
    logic        wd_enabled;
    logic        wd_window;
    logic [17:0] wd_period;
    logic        wd_tick;
    logic [17:0] wd_count_ff;
    logic        key_seen_ff;
    logic        early;
    logic        bad_write;
    logic        serviced;

    assign wd_sel     = opt1_ff[sysopt_pkg::OPT1_TIMEOUT_HI:sysopt_pkg::OPT1_TIMEOUT_LO];
    assign wd_busclk  = opt2_ff[sysopt_pkg::OPT2_CLKSEL];
    assign wd_enabled = (wd_sel != 2'b00);                                  // see R21
    assign wd_window  = opt2_ff[sysopt_pkg::OPT2_WINDOW] && wd_busclk;       // see R08
    assign wd_tick    = wd_busclk ? 1'b1 : sys_in.slow_tick;                 // see R06

    always_comb begin
        wd_period = sysopt_pkg::WD_BUS_LONG;
        case ({wd_busclk, wd_sel})                                           // see R04
            3'b001:  wd_period = sysopt_pkg::WD_SLOW_SHORT;
            3'b010:  wd_period = sysopt_pkg::WD_SLOW_MID;
            3'b011:  wd_period = sysopt_pkg::WD_SLOW_LONG;
            3'b101:  wd_period = sysopt_pkg::WD_BUS_SHORT;
            3'b110:  wd_period = sysopt_pkg::WD_BUS_MID;
            default: wd_period = sysopt_pkg::WD_BUS_LONG;
        endcase
    end

    // First 75% of the period: count below three quarters
    assign early = wd_window
                && ({2'b00, wd_count_ff} < ({2'b00, wd_period} - {4'h0, wd_period[17:2]})); // see R07

    assign serviced  = wr_cause && key_seen_ff && (wdata == sysopt_pkg::KEY_SECOND);
    assign bad_write = wd_enabled && wr_cause
                    && (early
                     || !((wdata == sysopt_pkg::KEY_FIRST)
                       || (wdata == sysopt_pkg::KEY_SECOND && key_seen_ff))); // see R20

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            key_seen_ff <= 1'b0;
        end else if (wr_cause) begin
            key_seen_ff <= (wdata == sysopt_pkg::KEY_FIRST);
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            wd_count_ff <= '0;
        end else if (!wd_enabled || serviced) begin
            wd_count_ff <= '0;
        end else if (wd_tick && (wd_count_ff < wd_period)) begin
            wd_count_ff <= wd_count_ff + 18'h0_0001;
        end
    end

    sysopt_pkg::wd_state_t wd_state_ff;

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            wd_state_ff <= sysopt_pkg::WD_IDLE;
        end else begin
            case (wd_state_ff)
                sysopt_pkg::WD_IDLE: begin
                    if (wd_enabled) begin
                        wd_state_ff <= sysopt_pkg::WD_ARMED;
                    end
                end
                sysopt_pkg::WD_ARMED: begin
                    if (bad_write || (wd_count_ff >= wd_period)) begin
                        wd_state_ff <= sysopt_pkg::WD_RESET;
                    end
                end
                // Held until the system reset pulls nrst
                sysopt_pkg::WD_RESET: wd_state_ff <= sysopt_pkg::WD_RESET;
                default: wd_state_ff <= sysopt_pkg::WD_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // System outputs, all registered

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            sys_out <= '0;
        end else begin
            sys_out.illegal_opcode_reset    <= sys_in.stop_request
                                            && !opt1_ff[sysopt_pkg::OPT1_STOP];       // see R05
            sys_out.watchdog_reset          <= (wd_state_ff == sysopt_pkg::WD_RESET);
            sys_out.supply_detect_reset     <= detect_on && pm_ff[sysopt_pkg::PM_DRE]
                                            && sys_in.supply_detect;                  // see R16
            sys_out.supply_warning_irq      <= wflag_ff && pm_ff[sysopt_pkg::PM_WIE]; // see R15
            sys_out.reference_buffer_enable <= pm_ff[sysopt_pkg::PM_REFERENCE_BUFFER_ENABLE];           // see R19
            sys_out.supply_detect_active    <= detect_on;                             // see R18
            sys_out.stop_permitted          <= opt1_ff[sysopt_pkg::OPT1_STOP];       // see R05
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read data

    logic [7:0] rd_byte;
    logic [7:0] pm_view;

    assign pm_view = {wflag_ff, 1'b0, pm_ff[5:2], 1'b0, pm_ff[0]};

    always_comb begin
        if (haddr[11:0] == sysopt_pkg::OFF_OPTIONS_ONE) begin
            rd_byte = opt1_ff;
        end else if (haddr[11:0] == sysopt_pkg::OFF_OPTIONS_TWO) begin
            rd_byte = opt2_ff;
        end else if (haddr[11:0] == sysopt_pkg::OFF_IDENT_HIGH) begin
            rd_byte = {1'b1, sysopt_pkg::IDH_RESERVED, PART_NUMBER[11:8]}; // see R09 see R10 see R11 see R12
        end else if (haddr[11:0] == sysopt_pkg::OFF_IDENT_LOW) begin
            rd_byte = PART_NUMBER[7:0];                                     // see R12
        end else if (haddr[11:0] == sysopt_pkg::OFF_POWER_MON) begin
            rd_byte = pm_view;
        end else if (haddr[11:0] == sysopt_pkg::OFF_WDOG_CTRL) begin
            rd_byte = wd_count_ff[17:10];
        end else begin
            rd_byte = 8'h00;
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            hrdata <= '0;
        end else if (take_req && !hwrite) begin
            hrdata <= {24'h00_0000, rd_byte};
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Assertions

    property p_opt1_once;
        @(posedge clk_sys) disable iff (!nrst)
        opt1_done_ff |=> $stable(opt1_ff);
    endproperty
    a_opt1_once: assert property (p_opt1_once) else $error("option one changed twice"); // see R01

    property p_opt2_once;
        @(posedge clk_sys) disable iff (!nrst)
        opt2_done_ff |=> $stable(opt2_ff) && opt2_done_ff;
    endproperty
    a_opt2_once: assert property (p_opt2_once) else $error("option two changed twice"); // see R22

    property p_spare_store;
        @(posedge clk_sys) disable iff (!nrst)
        (wr_opt1 && !opt1_done_ff) |=> opt1_ff[4] == $past(wdata[4]);
    endproperty
    a_spare_store: assert property (p_spare_store) else $error("spare bit not stored"); // see R03

    property p_stop_illegal;
        @(posedge clk_sys) disable iff (!nrst)
        (sys_in.stop_request && !opt1_ff[5]) |=> sys_out.illegal_opcode_reset;
    endproperty
    a_stop_illegal: assert property (p_stop_illegal) else $error("no illegal stop reset"); // see R05

    property p_no_wd_off;
        @(posedge clk_sys) disable iff (!nrst)
        (wd_sel == 2'b00) [*2] |=> !sys_out.watchdog_reset;
    endproperty
    a_no_wd_off: assert property (p_no_wd_off) else $error("reset with watchdog off"); // see R21

    property p_flag_sets;
        @(posedge clk_sys) disable iff (!nrst)
        sys_in.supply_warning |=> wflag_ff;
    endproperty
    a_flag_sets: assert property (p_flag_sets) else $error("warning flag missed"); // see R13

    property p_ack_clears;
        @(posedge clk_sys) disable iff (!nrst)
        (wr_pm && wdata[6] && !sys_in.supply_warning) |=> !wflag_ff;
    endproperty
    a_ack_clears: assert property (p_ack_clears) else $error("ack did not clear"); // see R14

    property p_irq;
        @(posedge clk_sys) disable iff (!nrst)
        sys_out.supply_warning_irq |-> $past(wflag_ff) && $past(pm_ff[5]);
    endproperty
    a_irq: assert property (p_irq) else $error("irq without cause"); // see R15

    property p_detect_reset;
        @(posedge clk_sys) disable iff (!nrst)
        sys_out.supply_detect_reset |-> $past(pm_ff[2]) && $past(pm_ff[4]);
    endproperty
    a_detect_reset: assert property (p_detect_reset) else $error("detect reset unqualified"); // see R16

    sequence s_first_key;
        wr_cause && wdata == 8'h55 && wd_enabled && !early;
    endsequence
    sequence s_bad_key;
        wr_cause && wdata != 8'h55 && wdata != 8'hAA && wd_enabled;
    endsequence
    property p_bad_key;
        @(posedge clk_sys) disable iff (!nrst)
        (s_bad_key and (wd_state_ff == sysopt_pkg::WD_ARMED)) |=> ##0 wd_state_ff == sysopt_pkg::WD_RESET;
    endproperty
    a_bad_key: assert property (p_bad_key) else $error("bad key not punished"); // see R20

    property p_window;
        @(posedge clk_sys) disable iff (!nrst)
        (wr_cause && early && wd_enabled && wd_state_ff == sysopt_pkg::WD_ARMED)
            |=> wd_state_ff == sysopt_pkg::WD_RESET ##1 sys_out.watchdog_reset;
    endproperty
    a_window: assert property (p_window) else $error("early service not punished"); // see R07

    property p_window_clk;
        @(posedge clk_sys) disable iff (!nrst)
        !wd_busclk |-> !early;
    endproperty
    a_window_clk: assert property (p_window_clk) else $error("window on slow clock"); // see R08

    property p_first_key;
        @(posedge clk_sys) disable iff (!nrst)
        s_first_key |=> key_seen_ff;
    endproperty
    a_first_key: assert property (p_first_key) else $error("first key not recorded"); // see R20

    // Stop without the stop qualifier must silence the detector
    property p_stop_detect;
        @(posedge clk_sys) disable iff (!nrst)
        (in_stop_ff && !pm_ff[sysopt_pkg::PM_DSE]) |=> !sys_out.supply_detect_active;
    endproperty
    a_stop_detect: assert property (p_stop_detect) else $error("detect ran in stop"); // see R17

endmodule

// ### dv/tb_top.sv
// Self-checking bench for the system option, ident and power monitor register bank
`timescale 1ns/10ps

`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin failures++; \
    $display("FAIL %0t mismatch got %h expected %h", $time, (got), (exp)); end end

module tb_top;
    // Part number is arbitrary, chosen only to differ from the design default
    localparam logic [11:0] PART = 12'h3C6;

    typedef struct packed {
        logic [11:0] addr;
        logic [7:0]  exp;
    } row_t;

    // Reset values, ident values and an unmapped place that reads zero
    localparam row_t ROWS [7] = '{
        '{sysopt_pkg::OFF_OPTIONS_ONE, 8'hD3},
        '{sysopt_pkg::OFF_OPTIONS_TWO, 8'h00},
        '{sysopt_pkg::OFF_IDENT_HIGH,  {1'b1, 3'b000, PART[11:8]}},
        '{sysopt_pkg::OFF_IDENT_LOW,   PART[7:0]},
        '{sysopt_pkg::OFF_POWER_MON,   8'h1C},
        '{sysopt_pkg::OFF_RESET_CAUSE, 8'h00},
        '{12'h040,                     8'h00}
    };

    logic                 clk_sys;
    logic                 nrst;
    logic                 hsel;
    logic [31:0]          haddr;
    logic [1:0]           htrans;
    logic                 hwrite;
    logic [2:0]           hsize;
    logic [31:0]          hwdata;
    logic [31:0]          hrdata;
    logic                 hreadyout;
    logic                 hresp;
    sysopt_pkg::sys_in_t  sys_in;
    sysopt_pkg::sys_out_t sys_out;
    int                   failures;
    int                   n_compared;
    logic [7:0]           r;

    system_option_power_monitor_regs #(.PART_NUMBER(PART)) u_dut (
        .clk_sys   (clk_sys),
        .nrst      (nrst),
        .hsel      (hsel),
        .haddr     (haddr),
        .htrans    (htrans),
        .hwrite    (hwrite),
        .hsize     (hsize),
        .hwdata    (hwdata),
        .hready    (hreadyout),
        .hrdata    (hrdata),
        .hreadyout (hreadyout),
        .hresp     (hresp),
        .sys_in    (sys_in),
        .sys_out   (sys_out)
    );

    initial begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic conclude;
        if (failures == 0 && n_compared > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // The single slave never stretches, but the wait stays bounded anyway
    task automatic wait_ready;
        int n;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (hreadyout !== 1'b1 && n < 16);
        if (hreadyout !== 1'b1) begin
            failures++;
            $display("FAIL %0t bus wait timed out", $time);
            conclude();
        end
    endtask

    task automatic xfer(input logic wr, input logic [11:0] a, input logic [7:0] d,
                        output logic [7:0] rd);
        @(posedge clk_sys);
        hsel   <= 1'b1;
        haddr  <= {20'h0_0000, a};
        htrans <= sysopt_pkg::HTRANS_NONSEQ;
        hwrite <= wr;
        hsize  <= sysopt_pkg::HSIZE_WORD;
        wait_ready();
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= {24'h00_0000, d};
        wait_ready();
        rd = hrdata[7:0];
    endtask

    task automatic wr8(input logic [11:0] a, input logic [7:0] d);
        logic [7:0] dummy;
        xfer(1'b1, a, d, dummy);
    endtask

    task automatic rd8(input logic [11:0] a, output logic [7:0] rd);
        xfer(1'b0, a, 8'h00, rd);
    endtask

    task automatic do_reset(input int cyc);
        @(posedge clk_sys);
        nrst <= 1'b0;
        repeat (cyc) @(posedge clk_sys);
        nrst <= 1'b1;
    endtask

    task automatic stop_pulse(input logic exp);
        @(posedge clk_sys);
        sys_in.stop_request <= 1'b1;
        @(posedge clk_sys);
        sys_in.stop_request <= 1'b0;
        #1 `CHK(sys_out.illegal_opcode_reset, exp)
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        failures = 0;
        n_compared = 0;
        nrst = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0000_0000;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = sysopt_pkg::HSIZE_WORD;
        hwdata = 32'h0000_0000;
        sys_in = '0;
        do_reset(10);
        foreach (ROWS[i]) begin
            rd8(ROWS[i].addr, r);
            `CHK(r, ROWS[i].exp)
            `CHK(hresp, 1'b0)
        end
        stop_pulse(1'b1);
        wr8(sysopt_pkg::OFF_OPTIONS_ONE, 8'h30);
        rd8(sysopt_pkg::OFF_OPTIONS_ONE, r);
        `CHK(r, 8'h30)
        wr8(sysopt_pkg::OFF_OPTIONS_ONE, 8'hC0);
        rd8(sysopt_pkg::OFF_OPTIONS_ONE, r);
        `CHK(r, 8'h30)
        `CHK(sys_out.stop_permitted, 1'b1)
        stop_pulse(1'b0);
        wr8(sysopt_pkg::OFF_OPTIONS_TWO, 8'h80);
        wr8(sysopt_pkg::OFF_OPTIONS_TWO, 8'h00);
        rd8(sysopt_pkg::OFF_OPTIONS_TWO, r);
        `CHK(r, 8'h80)
        wr8(sysopt_pkg::OFF_IDENT_HIGH, 8'h00);
        wr8(sysopt_pkg::OFF_IDENT_LOW, 8'hFF);
        rd8(sysopt_pkg::OFF_IDENT_HIGH, r);
        `CHK(r, {1'b1, 3'b000, PART[11:8]})
        rd8(sysopt_pkg::OFF_IDENT_LOW, r);
        `CHK(r, PART[7:0])
        // Timeout field is now zero, so a bad key must not bite
        wr8(sysopt_pkg::OFF_RESET_CAUSE, 8'h12);
        repeat (4) @(posedge clk_sys);
        `CHK(sys_out.watchdog_reset, 1'b0)
        wr8(sysopt_pkg::OFF_POWER_MON, 8'h21);
        rd8(sysopt_pkg::OFF_POWER_MON, r);
        `CHK(r, 8'h21)
        `CHK(sys_out.reference_buffer_enable, 1'b1)
        wr8(sysopt_pkg::OFF_POWER_MON, 8'h3C);
        rd8(sysopt_pkg::OFF_POWER_MON, r);
        `CHK(r, 8'h28)
        sys_in.supply_warning <= 1'b1;
        repeat (3) @(posedge clk_sys);
        rd8(sysopt_pkg::OFF_POWER_MON, r);
        `CHK(r, 8'hA8)
        `CHK(sys_out.supply_warning_irq, 1'b1)
        wr8(sysopt_pkg::OFF_POWER_MON, 8'h68);
        rd8(sysopt_pkg::OFF_POWER_MON, r);
        `CHK(r, 8'hA8)
        sys_in.supply_warning <= 1'b0;
        repeat (3) @(posedge clk_sys);
        rd8(sysopt_pkg::OFF_POWER_MON, r);
        `CHK(r, 8'hA8)
        wr8(sysopt_pkg::OFF_POWER_MON, 8'h68);
        rd8(sysopt_pkg::OFF_POWER_MON, r);
        `CHK(r, 8'h28)
        `CHK(sys_out.supply_warning_irq, 1'b0)
        // Supply already low across a reset must leave the flag set
        sys_in.supply_warning <= 1'b1;
        do_reset(2);
        rd8(sysopt_pkg::OFF_POWER_MON, r);
        `CHK(r, 8'h9C)
        wr8(sysopt_pkg::OFF_POWER_MON, 8'h14);
        rd8(sysopt_pkg::OFF_POWER_MON, r);
        `CHK(r, 8'h94)
        sys_in.supply_detect <= 1'b1;
        repeat (3) @(posedge clk_sys);
        `CHK(sys_out.supply_detect_reset, 1'b1)
        `CHK(sys_out.supply_detect_active, 1'b1)
        sys_in.supply_detect <= 1'b0;
        sys_in.supply_warning <= 1'b0;
        wr8(sysopt_pkg::OFF_POWER_MON, 8'h00);
        rd8(sysopt_pkg::OFF_POWER_MON, r);
        `CHK(r, 8'h94)
        wr8(sysopt_pkg::OFF_RESET_CAUSE, sysopt_pkg::KEY_FIRST);
        wr8(sysopt_pkg::OFF_RESET_CAUSE, sysopt_pkg::KEY_SECOND);
        repeat (4) @(posedge clk_sys);
        `CHK(sys_out.watchdog_reset, 1'b0)
        wr8(sysopt_pkg::OFF_RESET_CAUSE, 8'h12);
        repeat (4) @(posedge clk_sys);
        `CHK(sys_out.watchdog_reset, 1'b1)
        // Window bit with slow clock runs normal; with bus clock an early key resets
        for (int k = 0; k < 2; k++) begin
            do_reset(2);
            wr8(sysopt_pkg::OFF_OPTIONS_ONE, 8'h60);
            wr8(sysopt_pkg::OFF_OPTIONS_TWO, (k == 1) ? 8'hC0 : 8'h40);
            wr8(sysopt_pkg::OFF_RESET_CAUSE, sysopt_pkg::KEY_FIRST);
            wr8(sysopt_pkg::OFF_RESET_CAUSE, sysopt_pkg::KEY_SECOND);
            repeat (4) @(posedge clk_sys);
            `CHK(sys_out.watchdog_reset, 1'(k))
        end
        // Stop is permitted now; with the stop qualifier clear detection must pause
        wr8(sysopt_pkg::OFF_POWER_MON, 8'h14);
        sys_in.stop_request <= 1'b1;
        repeat (3) @(posedge clk_sys);
        `CHK(sys_out.supply_detect_active, 1'b0)
        sys_in.stop_request <= 1'b0;
        conclude();
    end
endmodule
